// File: core/usam_pkg.sv
// Shared constants and carrier types of the dual serial port.
package usam_pkg;
    // Register offsets.
    localparam logic [7:0] A_PWR = 8'h87;
    localparam logic [7:0] A_CLK = 8'h8e;
    localparam logic [7:0] A_CTL0 = 8'h98;
    localparam logic [7:0] A_BUF0 = 8'h99;
    localparam logic [7:0] A_ADR0 = 8'ha9;
    localparam logic [7:0] A_MSK0 = 8'hb9;
    localparam logic [7:0] A_CTL1 = 8'hb1;
    localparam logic [7:0] A_BUF1 = 8'ha1;
    localparam logic [7:0] A_ADR1 = 8'haa;
    localparam logic [7:0] A_MSK1 = 8'hab;
    // Field positions.
    localparam int C_FILT = 5;
    localparam int C_REN = 4;
    localparam int C_TB8 = 3;
    localparam int C_RB8 = 2;
    localparam int C_TI = 1;
    localparam int C_RI = 0;
    localparam int P_DBL = 7;
    localparam int K_T1SEL0 = 0;
    localparam int K_T1SEL1 = 1;
    // Mode field values.
    localparam logic [1:0] M_SHIFT = 2'h0;
    localparam logic [1:0] M_TEN = 2'h1;
    localparam logic [1:0] M_ELEVEN = 2'h2;
    // Reset values.
    localparam logic [7:0] R_BYTE = 8'h00;
    // Timing counts.
    localparam logic [1:0] M0_LAST_PH = 2'h3;
    localparam logic [2:0] M0_LAST_BIT = 3'h7;
    localparam logic [3:0] DIV_LAST = 4'hf;
    localparam logic [3:0] SMP_A = 4'h7;
    localparam logic [3:0] SMP_B = 4'h8;
    localparam logic [3:0] SMP_C = 4'h9;
    localparam logic [3:0] FRAME_TEN = 4'ha;
    localparam logic [3:0] FRAME_ELEVEN = 4'hb;
    // Bus write strobes for one port.
    typedef struct packed {
        logic ctl;
        logic dat;
        logic adr;
        logic msk;
        logic [7:0] data;
    } usam_wr_s;
    // Register view of one port.
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] rxbuf;
        logic [7:0] adr;
        logic [7:0] msk;
    } usam_regs_s;
    // State of one port.
    typedef struct packed {
        usam_regs_s r;
        logic [2:0] sync;
        logic filt;
        logic prev;
        logic half;
        logic [1:0] presc;
        logic m0_act;
        logic m0_rx;
        logic [1:0] m0_ph;
        logic [2:0] m0_bit;
        logic [7:0] m0_sh;
        logic m0_out;
        logic sclk_low;
        logic tx_act;
        logic [3:0] tx_div;
        logic [3:0] tx_cnt;
        logic [10:0] tx_sh;
        logic tx_low;
        logic rx_act;
        logic [3:0] rx_div;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic [1:0] smp;
    } usam_ch_s;
    // State of the top level.
    typedef struct packed {
        logic [7:0] pwr;
        logic [7:0] clkc;
        logic [7:0] rdata;
    } usam_top_s;
endpackage

// File: core/usam_top.sv
// Dual serial port with shift and asynchronous frame modes.
`timescale 1ns/1ps
`default_nettype none

module usam_chan
    import usam_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Register access.
    input wire usam_wr_s wr,
    output usam_regs_s regs,
    // Rate sources.
    input wire logic dbl,
    input wire logic use_t1,
    input wire logic t1_ovf,
    input wire logic t2_ovf,
    // Lines.
    input wire logic rx_i,
    output logic rx_o,
    output logic rx_oe_n,
    output logic tx_o,
    output logic irq
);
    usam_ch_s s_reg;
    usam_ch_s s_next;
    logic [1:0] mode;
    logic src;
    logic tick;
    logic roll;
    logic maj;
    logic [3:0] last;

    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [3:0] frame_len(input logic [1:0] m);
        frame_len = (m == M_TEN) ? FRAME_TEN : FRAME_ELEVEN;
    endfunction

    assign mode = s_reg.r.ctl[7:6];
    assign regs = s_reg.r;
    assign last = frame_len(mode) - 4'h1;
    assign src = use_t1 ? t1_ovf : t2_ovf;
    assign roll = tick & (s_reg.tx_div == DIV_LAST);
    assign maj = maj3(s_reg.smp[0], s_reg.smp[1], s_reg.filt);
    assign rx_o = s_reg.m0_out;
    assign rx_oe_n = ~(s_reg.m0_act & ~s_reg.m0_rx);
    assign tx_o = (mode == M_SHIFT) ? ~s_reg.sclk_low : ~s_reg.tx_low;
    assign irq = s_reg.r.ctl[C_TI] | s_reg.r.ctl[C_RI];

    always_comb
    begin
        // Sixteen-times bit rate tick.
        if (mode == M_ELEVEN)
        begin
            tick = dbl ? s_reg.presc[0] : (s_reg.presc == 2'h3);
        end
        else if (!use_t1 || dbl)
        begin
            tick = src;
        end
        else
        begin
            tick = src & s_reg.half;
        end
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.presc = s_reg.presc + 2'h1;
        if (src)
        begin
            s_next.half = ~s_reg.half;
        end
        // Line filter: a change counts once two stages agree.
        s_next.sync = {s_reg.sync[1:0], rx_i};
        if (s_reg.sync[1] == s_reg.sync[2])
        begin
            s_next.filt = s_reg.sync[1];
        end
        s_next.prev = s_reg.filt;
        // Software writes; hardware sets below override clears.
        if (wr.ctl)
        begin
            s_next.r.ctl = wr.data;
        end
        if (wr.adr)
        begin
            s_next.r.adr = wr.data;
        end
        if (wr.msk)
        begin
            s_next.r.msk = wr.data;
        end
        // Shift mode sequencer, four clocks per bit.
        if (s_reg.m0_act)
        begin
            s_next.m0_ph = s_reg.m0_ph + 2'h1;
            s_next.sclk_low = s_next.m0_ph[1];
            if (s_reg.m0_ph == M0_LAST_PH)
            begin
                s_next.m0_bit = s_reg.m0_bit + 3'h1;
                if (s_reg.m0_rx)
                begin
                    // The third stage is used; the filter would be late.
                    s_next.m0_sh = {s_reg.sync[2], s_reg.m0_sh[7:1]};
                end
                else
                begin
                    s_next.m0_sh = {1'b0, s_reg.m0_sh[7:1]};
                    s_next.m0_out = s_reg.m0_sh[1];
                end
                if (s_reg.m0_bit == M0_LAST_BIT)
                begin
                    s_next.m0_act = 1'b0;
                    s_next.sclk_low = 1'b0;
                    if (s_reg.m0_rx)
                    begin
                        s_next.r.rxbuf = {s_reg.sync[2], s_reg.m0_sh[7:1]};
                        s_next.r.ctl[C_RI] = 1'b1;
                    end
                    else
                    begin
                        s_next.r.ctl[C_TI] = 1'b1;
                    end
                end
            end
        end
        else if (mode == M_SHIFT && s_reg.r.ctl[C_REN] &&
                 !s_reg.r.ctl[C_RI] && !wr.dat)
        begin
            s_next.m0_act = 1'b1;
            s_next.m0_rx = 1'b1;
            s_next.m0_ph = 2'h0;
            s_next.m0_bit = 3'h0;
        end
        if (wr.dat && mode == M_SHIFT)
        begin
            s_next.m0_act = 1'b1;
            s_next.m0_rx = 1'b0;
            s_next.m0_ph = 2'h0;
            s_next.m0_bit = 3'h0;
            s_next.m0_sh = wr.data;
            s_next.m0_out = wr.data[0];
            s_next.sclk_low = 1'b0;
        end
        // Asynchronous transmit on free-running counter roll-overs.
        if (tick)
        begin
            s_next.tx_div = s_reg.tx_div + 4'h1;
        end
        if (roll && s_reg.tx_act)
        begin
            s_next.tx_low = ~s_reg.tx_sh[0];
            s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
            s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
            if (s_reg.tx_cnt == last)
            begin
                s_next.tx_act = 1'b0;
                s_next.r.ctl[C_TI] = 1'b1;
            end
        end
        if (wr.dat && mode != M_SHIFT)
        begin
            s_next.tx_act = 1'b1;
            s_next.tx_cnt = 4'h0;
            if (mode == M_TEN)
            begin
                s_next.tx_sh = {2'h3, wr.data, 1'b0};
            end
            else
            begin
                s_next.tx_sh = {1'b1, s_reg.r.ctl[C_TB8], wr.data,
                                1'b0};
            end
        end
        // Asynchronous receive.
        if (!s_reg.rx_act)
        begin
            if (mode != M_SHIFT && s_reg.r.ctl[C_REN] && s_reg.prev &&
                !s_reg.filt)
            begin
                s_next.rx_act = 1'b1;
                s_next.rx_div = 4'h0;
                s_next.rx_bit = 4'h0;
            end
        end
        else if (tick)
        begin
            s_next.rx_div = s_reg.rx_div + 4'h1;
            if (s_reg.rx_div == SMP_A)
            begin
                s_next.smp[0] = s_reg.filt;
            end
            if (s_reg.rx_div == SMP_B)
            begin
                s_next.smp[1] = s_reg.filt;
            end
            if (s_reg.rx_div == SMP_C)
            begin
                s_next.rx_bit = s_reg.rx_bit + 4'h1;
                if (s_reg.rx_bit == 4'h0)
                begin
                    if (maj)
                    begin
                        s_next.rx_act = 1'b0;
                    end
                end
                else if (s_reg.rx_bit != last)
                begin
                    s_next.rx_sh = {maj, s_reg.rx_sh[8:1]};
                end
                else
                begin
                    s_next.rx_act = 1'b0;
                    if (!s_reg.r.ctl[C_RI] &&
                        (!s_reg.r.ctl[C_FILT] || maj))
                    begin
                        s_next.r.ctl[C_RI] = 1'b1;
                        if (mode == M_TEN)
                        begin
                            s_next.r.rxbuf = s_reg.rx_sh[8:1];
                            s_next.r.ctl[C_RB8] = maj;
                        end
                        else
                        begin
                            s_next.r.rxbuf = s_reg.rx_sh[7:0];
                            s_next.r.ctl[C_RB8] = s_reg.rx_sh[8];
                        end
                    end
                end
            end
        end
        if (mode == M_SHIFT)
        begin
            s_next.rx_act = 1'b0;
            s_next.tx_act = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule

module usam_top
    import usam_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SRST,
    // Register port.
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Timer overflow pulses.
    input wire logic T1_OVF,
    input wire logic T2_OVF,
    // Port 0 lines.
    input wire logic P0_RX_I,
    output logic P0_RX_O,
    output logic P0_RX_OE_N,
    output logic P0_TX,
    output logic P0_IRQ,
    // Port 1 lines.
    input wire logic P1_RX_I,
    output logic P1_RX_O,
    output logic P1_RX_OE_N,
    output logic P1_TX,
    output logic P1_IRQ
);
    usam_top_s t_reg;
    usam_top_s t_next;
    usam_wr_s wr0;
    usam_wr_s wr1;
    usam_regs_s regs0;
    usam_regs_s regs1;

    assign RDATA = t_reg.rdata;

    always_comb
    begin
        wr0 = '0;
        wr1 = '0;
        wr0.data = WDATA;
        wr1.data = WDATA;
        wr0.ctl = WR && ADDR == A_CTL0;
        wr0.dat = WR && ADDR == A_BUF0;
        wr0.adr = WR && ADDR == A_ADR0;
        wr0.msk = WR && ADDR == A_MSK0;
        wr1.ctl = WR && ADDR == A_CTL1;
        wr1.dat = WR && ADDR == A_BUF1;
        wr1.adr = WR && ADDR == A_ADR1;
        wr1.msk = WR && ADDR == A_MSK1;
    end

    always_comb
    begin
        t_next = t_reg;
        t_next.rdata = R_BYTE;
        if (WR && ADDR == A_PWR)
        begin
            t_next.pwr = WDATA;
        end
        if (WR && ADDR == A_CLK)
        begin
            t_next.clkc = WDATA;
        end
        if (RD)
        begin
            unique case (ADDR)
                A_PWR: t_next.rdata = t_reg.pwr;
                A_CLK: t_next.rdata = t_reg.clkc;
                A_CTL0: t_next.rdata = regs0.ctl;
                A_BUF0: t_next.rdata = regs0.rxbuf;
                A_ADR0: t_next.rdata = regs0.adr;
                A_MSK0: t_next.rdata = regs0.msk;
                A_CTL1: t_next.rdata = regs1.ctl;
                A_BUF1: t_next.rdata = regs1.rxbuf;
                A_ADR1: t_next.rdata = regs1.adr;
                A_MSK1: t_next.rdata = regs1.msk;
                default: t_next.rdata = R_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            t_reg <= '0;
        end
        else
        begin
            t_reg <= t_next;
        end
    end

    usam_chan u_port0 (
        .clk(CLK),
        .srst(SRST),
        .wr(wr0),
        .regs(regs0),
        .dbl(t_reg.pwr[P_DBL]),
        .use_t1(t_reg.clkc[K_T1SEL0]),
        .t1_ovf(T1_OVF),
        .t2_ovf(T2_OVF),
        .rx_i(P0_RX_I),
        .rx_o(P0_RX_O),
        .rx_oe_n(P0_RX_OE_N),
        .tx_o(P0_TX),
        .irq(P0_IRQ)
    );

    usam_chan u_port1 (
        .clk(CLK),
        .srst(SRST),
        .wr(wr1),
        .regs(regs1),
        .dbl(t_reg.pwr[P_DBL]),
        .use_t1(t_reg.clkc[K_T1SEL1]),
        .t1_ovf(T1_OVF),
        .t2_ovf(T2_OVF),
        .rx_i(P1_RX_I),
        .rx_o(P1_RX_O),
        .rx_oe_n(P1_RX_OE_N),
        .tx_o(P1_TX),
        .irq(P1_IRQ)
    );
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the dual serial port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import usam_pkg::*;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic T1_OVF = 1'b0;
    logic T2_OVF = 1'b0;
    logic [7:0] RDATA;
    logic P0_RX_O, P0_RX_OE_N, P0_TX, P0_IRQ;
    logic P1_RX_O, P1_RX_OE_N, P1_TX, P1_IRQ;
    logic sel = 1'b0;
    logic peer_rx;
    int err_total = 0;
    int checks_done = 0;
    wire s_o = sel ? P1_RX_O : P0_RX_O;
    wire s_oe_n = sel ? P1_RX_OE_N : P0_RX_OE_N;
    wire s_tx = sel ? P1_TX : P0_TX;
    wire s_irq = sel ? P1_IRQ : P0_IRQ;
    wire line0 = P0_RX_OE_N ? (sel | peer_rx) : P0_RX_O;
    wire line1 = P1_RX_OE_N ? (!sel | peer_rx) : P1_RX_O;
    always #12.5 CLK = ~CLK;
    always @(posedge CLK)
    begin
        T1_OVF <= ~T1_OVF;
        T2_OVF <= ~T2_OVF;
    end
    usam_top usam_top_inst (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
        .T1_OVF, .T2_OVF, .P0_RX_I(line0), .P0_RX_O, .P0_RX_OE_N, .P0_TX,
        .P0_IRQ, .P1_RX_I(line1), .P1_RX_O, .P1_RX_OE_N, .P1_TX, .P1_IRQ);
    usam_peer usam_peer_inst (.clk(CLK), .tx(s_tx), .rx(peer_rx));
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] exp,
        input logic [10:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk("register", exp, RDATA);
        @(posedge CLK);
    endtask
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && s_irq !== 1'b1; i++)
            @(posedge CLK);
        chk("flag", 1'b1, s_irq);
        if (s_irq !== 1'b1)
            results();
    endtask
    task automatic t_regs();
        rchk(A_CTL0, R_BYTE);
        rchk(A_BUF1, R_BYTE);
        rchk(A_MSK1, R_BYTE);
        wr(A_MSK1, 8'h5a);
        rchk(A_MSK1, 8'h5a);
        rchk(8'h80, 8'h00);
    endtask
    task automatic t_m0_tx(input logic p, input logic [7:0] d);
        logic [7:0] c;
        c = p ? A_CTL1 : A_CTL0;
        sel = p;
        wr(c, 8'h00);
        wr(p ? A_BUF1 : A_BUF0, d);
        for (int k = 0; k < 32; k++)
        begin
            #1 chk("shift data", d[k / 4], s_o);
            chk("drive", 1'b0, s_oe_n);
            chk("shift clock", k % 4 < 2, s_tx);
            chk("early flag", 1'b0, s_irq);
            @(posedge CLK);
        end
        #1 chk("done flag", 1'b1, s_irq);
        @(posedge CLK);
        rchk(p ? A_BUF1 : A_BUF0, 8'h00);
        rchk(c, 8'h02);
        wr(c, 8'h00);
    endtask
    task automatic t_m0_rx(input logic [7:0] d);
        sel = 1'b0;
        usam_peer_inst.shift_load(d);
        wr(A_CTL0, 8'h10);
        wait_irq(200);
        rchk(A_BUF0, d);
        rchk(A_CTL0, 8'h11);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge CLK);
            #1 chk("halted", 1'b1, P0_TX);
        end
        @(posedge CLK);
        wr(A_CTL0, 8'h00);
    endtask
    task automatic t_tx(input logic [7:0] ctl, input logic [7:0] pwr,
        input logic [7:0] ck, input int n, input int per);
        logic [10:0] got;
        logic ok;
        logic [7:0] d;
        d = 8'h3c ^ ctl ^ ck;
        sel = 1'b0;
        wr(A_PWR, pwr);
        wr(A_CLK, ck);
        wr(A_CTL0, ctl);
        fork
            wr(A_BUF0, d);
            usam_peer_inst.catch_frame(n, per, got, ok);
        join
        chk("start seen", 1'b1, ok);
        chk("frame", n == 10 ? {2'b11, d, 1'b0}
            : {1'b1, ctl[C_TB8], d, 1'b0}, got);
        wait_irq(2 * per);
        rchk(A_CTL0, ctl | 8'h02);
        wr(A_CTL0, 8'h00);
    endtask
    task automatic rx_one(input logic [10:0] bits, input int n, input int per,
        input logic [7:0] ctl_exp, input logic [7:0] buf_exp);
        usam_peer_inst.send(bits, n, per);
        repeat (70) @(posedge CLK);
        rchk(A_CTL0, ctl_exp);
        rchk(A_BUF0, buf_exp);
    endtask
    task automatic t_rx();
        sel = 1'b0;
        wr(A_PWR, 8'h00);
        wr(A_CLK, 8'h00);
        wr(A_CTL0, 8'h90);
        rx_one({2'b11, 8'ha5, 1'b0}, 11, 64, 8'h95, 8'ha5);
        rx_one({2'b10, 8'h3c, 1'b0}, 11, 64, 8'h95, 8'ha5);
        wr(A_CTL0, 8'hb0);
        rx_one(11'h000, 1, 10, 8'hb0, 8'ha5);
        rx_one({2'b01, 8'h3c, 1'b0}, 11, 64, 8'hb0, 8'ha5);
        rx_one({2'b11, 8'h3c, 1'b0}, 11, 64, 8'hb5, 8'h3c);
        wr(A_CTL0, 8'h50);
        rx_one({2'b01, 8'h69, 1'b0}, 10, 32, 8'h55, 8'h69);
        wr(A_CTL0, 8'h70);
        rx_one({2'b00, 8'h96, 1'b0}, 10, 32, 8'h70, 8'h69);
        wr(A_CTL0, 8'h00);
    endtask
    initial
    begin
        repeat (8) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        t_regs();
        t_m0_tx(1'b0, 8'h96);
        t_m0_tx(1'b1, 8'h4b);
        t_m0_rx(8'hc3);
        t_tx(8'h88, 8'h00, 8'h00, 11, 64);
        t_tx(8'h80, 8'h80, 8'h00, 11, 32);
        t_tx(8'h40, 8'h00, 8'h00, 10, 32);
        t_tx(8'h40, 8'h00, 8'h01, 10, 64);
        t_tx(8'h40, 8'h80, 8'h01, 10, 32);
        t_rx();
        results();
    end
    initial
    begin
        #2400000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire

// File: testbench/usam_peer.sv
// Model of the far serial device: sender, frame catcher and shifter.
`timescale 1ns/1ps
`default_nettype none
module usam_peer (
    // Clock.
    input wire logic clk,
    // Lines.
    input wire logic tx,
    output logic rx
);
    logic [7:0] sh = 8'hff;
    logic [2:0] cnt = 3'h0;
    logic on = 1'b0;
    initial rx = 1'b1;
    // Next bit goes out as the shift clock rises; released line is high.
    always @(posedge tx)
    begin
        if (on)
        begin
            rx <= (cnt == 3'h7) ? 1'b1 : sh[cnt + 3'h1];
            on <= (cnt != 3'h7);
            cnt <= cnt + 3'h1;
        end
    end
    task automatic shift_load(input logic [7:0] d);
        sh = d;
        cnt = 3'h0;
        on = 1'b1;
        rx <= d[0];
    endtask
    task automatic send(input logic [10:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++)
        begin
            rx <= bits[i];
            repeat (per) @(posedge clk);
        end
        rx <= 1'b1;
    endtask
    task automatic catch_frame(input int n, input int per,
        output logic [10:0] got, output logic ok);
        got = 11'h7ff;
        ok = 1'b0;
        for (int w = 0; w < 4000 && !ok; w++)
        begin
            @(posedge clk);
            ok = !tx;
        end
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            got[i] = tx;
            repeat (per) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/usam_props.sv
// Checker of the serial port pins, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module usam_props
    import usam_pkg::*;
(
    // Clock, reset and register port.
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Port lines.
    input wire logic P0_RX_O,
    input wire logic P0_RX_OE_N,
    input wire logic P0_TX,
    input wire logic P0_IRQ,
    input wire logic P1_RX_OE_N,
    input wire logic P1_TX,
    input wire logic P1_IRQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SRST);
    logic [5:0] low_cnt;
    always_ff @(posedge CLK)
    begin
        if (SRST || P0_RX_OE_N)
            low_cnt <= 6'h00;
        else
            low_cnt <= low_cnt + 6'h01;
    end
    a_read_rest: assert property (
        !$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
    a_clock_low0: assert property (
        $fell(P0_TX) && !P0_RX_OE_N |=> !P0_TX ##1 P0_TX)
        else $error("shift clock low phase wrong");
    a_bit_hold: assert property (
        $fell(P0_TX) && !P0_RX_OE_N |-> $stable(P0_RX_O)
        && P0_RX_O == $past(P0_RX_O, 2) ##1 $stable(P0_RX_O))
        else $error("shift data not held");
    a_shift_len: assert property (
        $rose(P0_RX_OE_N) |-> low_cnt == 6'h20 && P0_IRQ)
        else $error("shift transfer length wrong");
    a_clear_sw0: assert property (
        $fell(P0_IRQ) |-> $past(WR) && $past(ADDR) == A_CTL0)
        else $error("port 0 flag cleared without write");
    a_clear_sw1: assert property (
        $fell(P1_IRQ) |-> $past(WR) && $past(ADDR) == A_CTL1)
        else $error("port 1 flag cleared without write");
    a_stop_high: assert property (
        $rose(P0_IRQ) && P0_RX_OE_N |-> P0_TX)
        else $error("flag set before stop level");
    a_clock_low1: assert property (
        $fell(P1_TX) && !P1_RX_OE_N |=> !P1_TX ##1 P1_TX)
        else $error("port 1 shift clock wrong");
    c_shift_done: cover property ($rose(P0_RX_OE_N));
    c_flag_p1: cover property ($rose(P1_IRQ));
    c_clear_p0: cover property ($fell(P0_IRQ));
endmodule
bind usam_top usam_props usam_props_inst (.CLK, .SRST, .ADDR, .WR, .RD,
    .RDATA, .P0_RX_O, .P0_RX_OE_N, .P0_TX, .P0_IRQ, .P1_RX_OE_N, .P1_TX,
    .P1_IRQ);
`default_nettype wire
